// ---- core/spkamp_ctrl.sv ----
// Register file, mono mixer, volume and speaker protection control.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spkamp_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Serial audio pins
  input wire logic bitClkPin,
  input wire logic wordClkPin,
  input wire logic dataInPin,
  // Protection sensors and straps
  input wire logic shortDetect,
  input wire logic overTemp,
  input wire logic busSelectPin,
  // Mono sample to the DAC
  output logic signed [23:0] monoSample,
  output logic monoValid,
  // Speaker stage and configuration outputs
  output logic speakerEnable,
  output logic speakerSwitching,
  output logic [2:0] speakerGain,
  output logic [1:0] refClockSel,
  output logic [1:0] pllRefSel,
  output logic [9:0] oversampleRatio,
  output logic [1:0] interpSelect,
  output logic [7:0] analogPower,
  output logic spiMode
);
  import spkamp_pkg::*;

  spkamp_frame_t frame;
  spkamp_req_t req;
  spkamp_state_t state;
  spkamp_state_t next_state;
  logic [1:0] shortSync;
  logic [1:0] hotSync;
  logic [1:0] selSync;
  logic [7:0] clkSel;
  logic [1:0] osrHi;
  logic [7:0] osrLo;
  logic [1:0] interp;
  logic signed [7:0] volume;
  logic [7:0] dacCtl;
  logic [1:0] mixSel;
  logic [7:0] anaPwr;
  logic [2:0] gain;
  logic powerReq;
  logic ocFlag;
  logic softReset;
  logic [5:0] zeroRun;
  logic signed [24:0] mixed;
  logic signed [33:0] scaled;

  spkamp_i2s_rx u_rx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .bitClkPin(bitClkPin),
    .wordClkPin(wordClkPin),
    .dataInPin(dataInPin),
    .frame(frame)
  );

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Saturating volume code so out-of-range writes stay inside the band.
  function automatic logic signed [7:0] clampVol(input logic [7:0] v);
    logic signed [7:0] s;
    s = signed'(v);
    if (s < VOL_MIN) begin
      clampVol = VOL_MIN;
    end else if (s > VOL_MAX) begin
      clampVol = VOL_MAX;
    end else begin
      clampVol = s;
    end
  endfunction : clampVol

  function automatic logic isWrite(input spkamp_req_t r, input logic [7:0] a);
    isWrite = r.wr && (r.addr == a);
  endfunction : isWrite

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shortSync <= 2'h0;
      hotSync <= 2'h0;
      selSync <= 2'h0;
    end else begin
      shortSync <= {shortSync[0], shortDetect};
      hotSync <= {hotSync[0], overTemp};
      selSync <= {selSync[0], busSelectPin};
    end
  end

  // The strap follows the synchronised pin on every cycle after reset release.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      spiMode <= 1'b0;
    end else begin
      spiMode <= selSync[1];
    end
  end

  // Either reset source returns every register to its default value.
  always_ff @(posedge mclk) begin
    if (sys_rst || softReset) begin
      clkSel <= RST_CLKSEL;
      osrHi <= RST_OSR_HI;
      osrLo <= RST_OSR_LO;
      interp <= RST_INTERP;
      volume <= RST_VOLUME;
      dacCtl <= RST_DACCTL;
      mixSel <= RST_MIX;
      anaPwr <= RST_ANAPWR;
      gain <= RST_GAIN;
    end else begin
      if (isWrite(req, ADDR_CLKSEL)) begin
        clkSel <= req.wdata;
      end
      if (isWrite(req, ADDR_OSR_HI)) begin
        osrHi <= req.wdata[1:0];
      end
      if (isWrite(req, ADDR_OSR_LO)) begin
        osrLo <= req.wdata;
      end
      if (isWrite(req, ADDR_INTERP)) begin
        // Code 3 is not a filter; it is ignored so a valid type remains.
        if (req.wdata[1:0] != 2'h3) begin
          interp <= req.wdata[1:0];
        end
      end
      if (isWrite(req, ADDR_VOLUME)) begin
        volume <= clampVol(req.wdata);
      end
      if (isWrite(req, ADDR_DACCTL)) begin
        dacCtl <= req.wdata;
      end
      if (isWrite(req, ADDR_MIXSEL)) begin
        mixSel <= req.wdata[MIX_LSB+1:MIX_LSB];
      end
      if (isWrite(req, ADDR_ANAPWR)) begin
        anaPwr <= req.wdata;
      end
      if (isWrite(req, ADDR_SPKGAIN)) begin
        gain <= req.wdata[GAIN_LSB+2:GAIN_LSB];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      softReset <= 1'b0;
    end else begin
      softReset <= isWrite(req, ADDR_SWRST) && req.wdata[SWRST_BIT];
    end
  end

  // Writing D1 is both power-on and power-stage restart request.
  always_ff @(posedge mclk) begin
    if (sys_rst || softReset) begin
      powerReq <= 1'b0;
    end else begin
      powerReq <= isWrite(req, ADDR_SPKPWR) && req.wdata[SPK_BIT];
    end
  end

  // A short seen in a restart cycle still wins and trips the stage again.
  always_comb begin
    next_state = state;
    case (state)
      SPKAMP_ST_OFF: begin
        if (powerReq && shortSync[1]) begin
          next_state = SPKAMP_ST_FAULT;
        end else if (powerReq) begin
          next_state = SPKAMP_ST_RUN;
        end
      end
      SPKAMP_ST_RUN: begin
        if (shortSync[1]) begin
          next_state = SPKAMP_ST_FAULT;
        end else if (hotSync[1]) begin
          next_state = SPKAMP_ST_HOT;
        end
      end
      SPKAMP_ST_HOT: begin
        if (shortSync[1]) begin
          next_state = SPKAMP_ST_FAULT;
        end else if (!hotSync[1]) begin
          next_state = SPKAMP_ST_RUN;
        end
      end
      SPKAMP_ST_FAULT: begin
        if (powerReq && !shortSync[1]) begin
          next_state = SPKAMP_ST_RUN;
        end
      end
      default: next_state = SPKAMP_ST_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || softReset) begin
      state <= SPKAMP_ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Flag reads one in normal operation and zero after a short.
  always_ff @(posedge mclk) begin
    if (sys_rst || softReset) begin
      ocFlag <= 1'b1;
    end else if (shortSync[1]) begin
      ocFlag <= 1'b0;
    end else if (powerReq) begin
      ocFlag <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || softReset) begin
      speakerEnable <= 1'b0;
      speakerSwitching <= 1'b0;
      speakerGain <= 3'h0;
    end else begin
      speakerEnable <= (next_state == SPKAMP_ST_RUN)
                       || (next_state == SPKAMP_ST_HOT);
      speakerSwitching <= (next_state == SPKAMP_ST_RUN);
      speakerGain <= gain;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      refClockSel <= 2'h0;
      pllRefSel <= 2'h0;
      oversampleRatio <= 10'h0;
      interpSelect <= 2'h0;
      analogPower <= 8'h00;
    end else begin
      refClockSel <= clkSel[CLKSEL_LSB+1:CLKSEL_LSB];
      pllRefSel <= clkSel[PLLSEL_LSB+1:PLLSEL_LSB];
      // Ratio code 0 stands for 1024; codes 1 to 1023 are taken as is.
      oversampleRatio <= {osrHi, osrLo};
      interpSelect <= interp;
      analogPower <= anaPwr;
    end
  end

  always_comb begin
    case (spkamp_mix_t'(mixSel))
      SPKAMP_MIX_LEFT: mixed = {frame.left[23], frame.left};
      SPKAMP_MIX_RIGHT: mixed = {frame.right[23], frame.right};
      // Signed operands keep the halving arithmetic for negative sums.
      SPKAMP_MIX_AVG: mixed = (signed'({frame.left[23], frame.left})
          + signed'({frame.right[23], frame.right})) >>> 1;
      default: mixed = 25'h0;
    endcase
  end

  // Volume in half-dB steps is approximated by a linear code over 128.
  assign scaled = 34'(mixed) * 34'(signed'({1'b0, 8'(volume + 8'sd128)}));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      zeroRun <= 6'h0;
    end else if (frame.valid) begin
      if (mixed == 25'h0) begin
        zeroRun <= (zeroRun == AUTOMUTE_CNT) ? zeroRun : zeroRun + 6'h1;
      end else begin
        zeroRun <= 6'h0;
      end
    end
  end

  // The sample rate is set by the source; this path accepts any frame pace.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      monoSample <= 24'h0;
      monoValid <= 1'b0;
    end else begin
      monoValid <= frame.valid;
      if (frame.valid) begin
        if (dacCtl[MUTE_BIT] || (dacCtl[AUTOMUTE_BIT]
            && zeroRun == AUTOMUTE_CNT)) begin
          monoSample <= 24'h0;
        end else begin
          monoSample <= scaled[30:7];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_CLKSEL: regRdata <= clkSel;
        ADDR_OSR_HI: regRdata <= {6'h0, osrHi};
        ADDR_OSR_LO: regRdata <= osrLo;
        ADDR_INTERP: regRdata <= {6'h0, interp};
        ADDR_VOLUME: regRdata <= volume;
        ADDR_DACCTL: regRdata <= dacCtl;
        ADDR_MIXSEL: regRdata <= {2'h0, mixSel, 4'h0};
        ADDR_OTSTAT: regRdata <= {hotSync[1], 7'h0};
        ADDR_SPKPWR: regRdata <= {6'h0, ocFlag, 1'b0};
        ADDR_ANAPWR: regRdata <= anaPwr;
        ADDR_SPKGAIN: regRdata <= {1'b0, gain, 4'h0};
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  a_short_trips: assert property (@(posedge mclk) disable iff (sys_rst)
    shortSync[1] && !softReset |=> !speakerEnable && !ocFlag)
    else $error("Short did not disable the speaker stage.");
  a_fault_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    state == SPKAMP_ST_FAULT && !powerReq && !softReset
    |=> !speakerEnable)
    else $error("Stage left fault without a reset.");
  a_hot_stops: assert property (@(posedge mclk) disable iff (sys_rst)
    hotSync[1] && state == SPKAMP_ST_RUN && !shortSync[1] && !softReset
    |=> !speakerSwitching)
    else $error("Switching continued while overheated.");
  a_restart_ok: assert property (@(posedge mclk) disable iff (sys_rst)
    state == SPKAMP_ST_FAULT && powerReq && !shortSync[1] && !softReset
    |=> speakerSwitching && ocFlag)
    else $error("Power-stage restart did not resume.");
  a_soft_default: assert property (@(posedge mclk) disable iff (sys_rst)
    softReset |=> gain == RST_GAIN && anaPwr == RST_ANAPWR)
    else $error("Software reset did not restore defaults.");
  a_gain_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    isWrite(req, ADDR_SPKGAIN) && !softReset
    |=> ##1 speakerGain == $past(req.wdata[6:4], 2))
    else $error("Driver gain did not follow its field.");
  a_ot_read: assert property (@(posedge mclk) disable iff (sys_rst)
    req.rd && req.addr == ADDR_OTSTAT |=> regRdata[7] == $past(hotSync[1]))
    else $error("Over-temperature flag read wrong.");
  a_mute_out: assert property (@(posedge mclk) disable iff (sys_rst)
    frame.valid && dacCtl[MUTE_BIT] |=> monoSample == 24'h0)
    else $error("Mute did not silence the sample.");
endmodule : spkamp_ctrl
`default_nettype wire

// ---- core/spkamp_pkg.sv ----
// Package of constants and types for the speaker amplifier control block.
package spkamp_pkg;
  // Register address is page bit followed by a 7-bit register number.
  localparam logic [7:0] ADDR_CLKSEL = 8'h04;
  localparam logic [7:0] ADDR_OSR_HI = 8'h0d;
  localparam logic [7:0] ADDR_OSR_LO = 8'h0e;
  localparam logic [7:0] ADDR_INTERP = 8'h0f;
  localparam logic [7:0] ADDR_VOLUME = 8'h41;
  localparam logic [7:0] ADDR_DACCTL = 8'h40;
  localparam logic [7:0] ADDR_OTSTAT = 8'h2d;
  localparam logic [7:0] ADDR_MIXSEL = 8'h3f;
  localparam logic [7:0] ADDR_SWRST = 8'h01;
  localparam logic [7:0] ADDR_SPKPWR = 8'had;
  localparam logic [7:0] ADDR_ANAPWR = 8'hae;
  localparam logic [7:0] ADDR_SPKGAIN = 8'hb0;
  // Field positions.
  localparam int MIX_LSB = 4;
  localparam int CLKSEL_LSB = 0;
  localparam int PLLSEL_LSB = 2;
  localparam int SPK_BIT = 1;
  localparam int GAIN_LSB = 4;
  localparam int OT_BIT = 7;
  localparam int MUTE_BIT = 3;
  localparam int AUTOMUTE_BIT = 2;
  localparam int ADAPT_BIT = 1;
  localparam int SWRST_BIT = 0;
  // Reset values.
  localparam logic [7:0] RST_CLKSEL = 8'h00;
  localparam logic [1:0] RST_OSR_HI = 2'h0;
  localparam logic [7:0] RST_OSR_LO = 8'h80;
  localparam logic [1:0] RST_INTERP = 2'h0;
  localparam logic [7:0] RST_VOLUME = 8'h00;
  localparam logic [7:0] RST_DACCTL = 8'h08;
  localparam logic [1:0] RST_MIX = 2'h0;
  localparam logic [7:0] RST_ANAPWR = 8'h00;
  localparam logic [2:0] RST_GAIN = 3'h0;
  // Volume codes in signed half-dB steps: -127 is -63.5 dB, 48 is +24 dB.
  localparam logic signed [7:0] VOL_MIN = 8'sh81;
  localparam logic signed [7:0] VOL_MAX = 8'sh30;
  localparam int SAMPLE_W = 24;
  localparam int SAMPLE_CYCLES = 64;
  localparam logic [5:0] AUTOMUTE_CNT = 6'h3f;
  // Sample rate band in Hz.
  localparam int RATE_MIN_HZ = 8000;
  localparam int RATE_MAX_HZ = 192000;

  typedef enum logic [1:0] {
    SPKAMP_MIX_LEFT = 2'h0,
    SPKAMP_MIX_RIGHT = 2'h1,
    SPKAMP_MIX_AVG = 2'h2,
    SPKAMP_MIX_OFF = 2'h3
  } spkamp_mix_t;

  typedef enum logic [3:0] {
    SPKAMP_ST_OFF = 4'h1,
    SPKAMP_ST_RUN = 4'h2,
    SPKAMP_ST_FAULT = 4'h4,
    SPKAMP_ST_HOT = 4'h8
  } spkamp_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spkamp_req_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
    logic valid;
  } spkamp_frame_t;
endpackage : spkamp_pkg

// ---- core/spkamp_i2s_rx.sv ----
// Serial audio receiver that collects a left and right 24-bit sample.
`timescale 1ns/1ps
`default_nettype none
module spkamp_i2s_rx (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial audio pins
  input wire logic bitClkPin,
  input wire logic wordClkPin,
  input wire logic dataInPin,
  // Received frame
  output spkamp_pkg::spkamp_frame_t frame
);
  import spkamp_pkg::*;

  logic [1:0] bclkSync;
  logic [1:0] wclkSync;
  logic [1:0] dinSync;
  logic bclkPrev;
  logic wclkPrev;
  logic [4:0] bitCount;
  logic [SAMPLE_W-1:0] shiftReg;
  logic [SAMPLE_W-1:0] leftHold;
  logic bclkRise;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bclkSync <= 2'h0;
      wclkSync <= 2'h0;
      dinSync <= 2'h0;
    end else begin
      bclkSync <= {bclkSync[0], bitClkPin};
      wclkSync <= {wclkSync[0], wordClkPin};
      dinSync <= {dinSync[0], dataInPin};
    end
  end

  assign bclkRise = bclkSync[1] & ~bclkPrev;

  // The MSB follows the word-clock edge by one bit clock, so counting starts
  // at the edge and the first captured bit is the MSB.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bclkPrev <= 1'b0;
      // Word clock rests high after a right word; starting from that level
      // lets the first left word after reset be seen.
      wclkPrev <= 1'b1;
      bitCount <= 5'h1f;
      shiftReg <= '0;
      leftHold <= '0;
      frame <= '0;
    end else begin
      bclkPrev <= bclkSync[1];
      frame.valid <= 1'b0;
      if (bclkRise) begin
        wclkPrev <= wclkSync[1];
        if (wclkSync[1] != wclkPrev) begin
          bitCount <= 5'h0;
        end else if (bitCount < 5'(SAMPLE_W)) begin
          shiftReg <= {shiftReg[SAMPLE_W-2:0], dinSync[1]};
          bitCount <= bitCount + 5'h1;
          if (bitCount == 5'(SAMPLE_W - 1)) begin
            if (!wclkPrev) begin
              leftHold <= {shiftReg[SAMPLE_W-2:0], dinSync[1]};
            end else begin
              frame.left <= leftHold;
              frame.right <= {shiftReg[SAMPLE_W-2:0], dinSync[1]};
              frame.valid <= 1'b1;
            end
          end
        end
      end
    end
  end

  a_frame_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    frame.valid |=> !frame.valid)
    else $error("Frame valid lasted more than one cycle.");
endmodule : spkamp_i2s_rx
`default_nettype wire

// ---- tb/spkamp_audio_src.sv ----
// Serial audio source that plays stereo frames into the receiver.
`timescale 1ns/1ps
`default_nettype none
module spkamp_audio_src (
  // Serial audio pins
  output logic bitClkPin,
  output logic wordClkPin,
  output logic dataInPin
);
  localparam int HALF_NS = 400;

  initial begin
    bitClkPin = 1'b0;
    wordClkPin = 1'b1;
    dataInPin = 1'b0;
  end

  // The bit clock runs only inside a frame and rests low between frames.
  // Each word has one delay slot before its MSB, as the I2S format does.
  task automatic send(input logic [23:0] l, input logic [23:0] r);
    logic [63:0] bits;
    bits = {1'b0, l, 7'h00, 1'b0, r, 7'h00};
    for (int i = 0; i < 64; i++) begin
      #HALF_NS bitClkPin = 1'b0;
      if (i == 0) begin
        wordClkPin = 1'b0;
      end
      if (i == 32) begin
        wordClkPin = 1'b1;
      end
      dataInPin = bits[63-i];
      #HALF_NS bitClkPin = 1'b1;
    end
    #HALF_NS bitClkPin = 1'b0;
    // Idle data shows the inverse so a stale bit is never mistaken for data.
    dataInPin = ~dataInPin;
  endtask : send
endmodule : spkamp_audio_src
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the speaker amplifier control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spkamp_pkg::*;
  localparam int LIMIT = 20000;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic bitClkPin, wordClkPin, dataInPin;
  logic shortDetect = 1'b0;
  logic overTemp = 1'b0;
  logic busSelectPin = 1'b0;
  logic signed [23:0] monoSample;
  logic monoValid, speakerEnable, speakerSwitching, spiMode;
  logic [2:0] speakerGain;
  logic [1:0] refClockSel, pllRefSel, interpSelect;
  logic [9:0] oversampleRatio;
  logic [7:0] analogPower;
  logic [23:0] gotMono = 24'h000000;
  logic [23:0] mixExp [4];
  int numErrors = 0;
  int numChecks = 0;
  int cycles = 0;

  always #50 mclk = ~mclk;

  spkamp_ctrl spkamp_ctrl_i (
    .mclk(mclk), .sys_rst(sysRst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata),
    .bitClkPin(bitClkPin), .wordClkPin(wordClkPin),
    .dataInPin(dataInPin), .shortDetect(shortDetect),
    .overTemp(overTemp), .busSelectPin(busSelectPin),
    .monoSample(monoSample), .monoValid(monoValid),
    .speakerEnable(speakerEnable), .speakerSwitching(speakerSwitching),
    .speakerGain(speakerGain), .refClockSel(refClockSel),
    .pllRefSel(pllRefSel), .oversampleRatio(oversampleRatio),
    .interpSelect(interpSelect), .analogPower(analogPower),
    .spiMode(spiMode)
  );

  spkamp_audio_src spkamp_audio_src_i (
    .bitClkPin(bitClkPin), .wordClkPin(wordClkPin),
    .dataInPin(dataInPin)
  );

  // The valid pulse lasts one cycle, so the sample is caught as it passes.
  always @(posedge mclk) begin
    if (monoValid === 1'b1) begin
      gotMono <= monoSample;
    end
  end

  task automatic closeOut();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : closeOut

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      numErrors++;
      $display("BAD %0t run did not finish", $time);
      closeOut();
    end
  end

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    numChecks++;
    if (g !== e) begin
      numErrors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
    chk(24'(d), 24'(e));
  endtask : rdchk

  task automatic play(input logic [23:0] l, input logic [23:0] r);
    // Start off the clock edge so pin changes never meet a sampling edge.
    cyc(1);
    spkamp_audio_src_i.send(l, r);
    cyc(20);
  endtask : play

  initial begin
    mixExp[0] = 24'h123456;
    mixExp[1] = 24'h0abcde;
    mixExp[2] = 24'h0e789a;
    mixExp[3] = 24'h000000;
    repeat (8) @(posedge mclk);
    sysRst <= 1'b0;
    cyc(3);
    chk(24'(speakerEnable), 24'h0);
    chk(24'(analogPower), 24'h0);
    chk(24'(oversampleRatio), 24'h080);
    rdchk(ADDR_DACCTL, RST_DACCTL);
    rdchk(ADDR_SPKPWR, 8'h02);
    rdchk(8'h7e, 8'h00);
    wr(8'h7e, 8'hff);
    rdchk(8'h7e, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CLKSEL, 8'(k * 5));
      cyc(3);
      chk(24'(refClockSel), 24'(k));
      chk(24'(pllRefSel), 24'(k));
    end
    rdchk(ADDR_CLKSEL, 8'h0f);
    wr(ADDR_OSR_HI, 8'h03);
    wr(ADDR_OSR_LO, 8'hff);
    cyc(3);
    chk(24'(oversampleRatio), 24'h3ff);
    wr(ADDR_OSR_HI, 8'h00);
    wr(ADDR_OSR_LO, 8'h00);
    cyc(3);
    chk(24'(oversampleRatio), 24'h000);
    wr(ADDR_INTERP, 8'h02);
    wr(ADDR_INTERP, 8'h03);
    cyc(3);
    chk(24'(interpSelect), 24'h2);
    rdchk(ADDR_INTERP, 8'h02);
    // Auto-mute on: frames that are not silent must still pass.
    wr(ADDR_DACCTL, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_MIXSEL, 8'(k * 16));
      play(24'h123456, 24'h0abcde);
      chk(gotMono, mixExp[k]);
    end
    wr(ADDR_MIXSEL, 8'h20);
    wr(ADDR_VOLUME, 8'h30);
    play(24'hfe0000, 24'hfe0000);
    chk(gotMono, 24'hfd4000);
    wr(ADDR_DACCTL, 8'h08);
    play(24'h020000, 24'h000100);
    chk(gotMono, 24'h000000);
    wr(ADDR_VOLUME, 8'h7f);
    rdchk(ADDR_VOLUME, 8'h30);
    wr(ADDR_VOLUME, 8'h80);
    rdchk(ADDR_VOLUME, 8'h81);
    wr(ADDR_ANAPWR, 8'h05);
    cyc(3);
    chk(24'(analogPower), 24'h05);
    busSelectPin <= 1'b1;
    cyc(6);
    chk(24'(spiMode), 24'h1);
    busSelectPin <= 1'b0;
    cyc(6);
    chk(24'(spiMode), 24'h0);
    wr(ADDR_SPKGAIN, 8'h50);
    cyc(3);
    chk(24'(speakerGain), 24'h5);
    rdchk(ADDR_SPKGAIN, 8'h50);
    wr(ADDR_SPKGAIN, 8'h00);
    cyc(3);
    chk(24'(speakerGain), 24'h0);
    wr(ADDR_SPKPWR, 8'h02);
    cyc(3);
    chk(24'({speakerEnable, speakerSwitching}), 24'h3);
    overTemp <= 1'b1;
    cyc(6);
    chk(24'({speakerEnable, speakerSwitching}), 24'h2);
    rdchk(ADDR_OTSTAT, 8'h80);
    wr(ADDR_OTSTAT, 8'h00);
    rdchk(ADDR_OTSTAT, 8'h80);
    overTemp <= 1'b0;
    cyc(6);
    chk(24'({speakerEnable, speakerSwitching}), 24'h3);
    rdchk(ADDR_OTSTAT, 8'h00);
    shortDetect <= 1'b1;
    cyc(6);
    chk(24'({speakerEnable, speakerSwitching}), 24'h0);
    rdchk(ADDR_SPKPWR, 8'h00);
    wr(ADDR_SPKPWR, 8'h02);
    cyc(4);
    chk(24'(speakerEnable), 24'h0);
    shortDetect <= 1'b0;
    cyc(6);
    chk(24'(speakerEnable), 24'h0);
    // Second restart request, the first that succeeds, inside the advised limit of three.
    wr(ADDR_SPKPWR, 8'h02);
    cyc(3);
    chk(24'({speakerEnable, speakerSwitching}), 24'h3);
    rdchk(ADDR_SPKPWR, 8'h02);
    rdchk(ADDR_VOLUME, 8'h81);
    wr(ADDR_SWRST, 8'h01);
    cyc(4);
    chk(24'(speakerEnable), 24'h0);
    rdchk(ADDR_VOLUME, RST_VOLUME);
    rdchk(ADDR_DACCTL, RST_DACCTL);
    rdchk(ADDR_ANAPWR, RST_ANAPWR);
    closeOut();
  end
endmodule : testbench
`default_nettype wire
